// *** hw/psr_xfer_consts.vh ***
// Encoding constants for the status-transfer decoder
`ifndef PSR_XFER_CONSTS_VH
`define PSR_XFER_CONSTS_VH
`define COND_HI        31
`define COND_LO        28
`define CLS_HI         27
`define CLS_LO         26
`define CLS_VAL        2'h0
`define IMM_BIT        25
`define OPC_HI         24
`define OPC_LO         23
`define OPC_VAL        2'h2
`define SEL_BIT        22
`define FLGPAT_HI      21
`define FLGPAT_LO      12
`define FLGPAT_VAL     10'h29f
`define FULLPAT_VAL    10'h28f
`define RDPAT_HI       21
`define RDPAT_LO       16
`define RDPAT_VAL      6'h0f
`define RD_HI          15
`define RD_LO          12
`define RDZERO_HI      11
`define RDZERO_LO      0
`define RM_HI          3
`define RM_LO          0
`define PAD_HI         11
`define PAD_LO         4
`define PAD_VAL        8'h00
`define ROT_HI         11
`define ROT_LO         8
`define IMM8_HI        7
`define IMM8_LO        0
`define TOPCLS_HI      27
`define TOPCLS_LO      23
`define TOPCLS_VAL     5'h02
`define FLAGS_HI       31
`define FLAGS_LO       28
`define FLAG_N         31
`define FLAG_Z         30
`define FLAG_C         29
`define FLAG_V         28
`define CTRL_HI        7
`define CTRL_LO        0
`define MODE_HI        4
`define MODE_LO        0
`define MODE_USER      5'h10
`define STATUS_RESET   32'h000000d3
`define DEFINED_MASK   32'hf00000ff
`define PC_REG         4'hf
`define OFS_STATUS     32'h00000000
`define OFS_SAVED      32'h00000004
`define OFS_INFO       32'h00000008
`endif

// *** hw/psr_transfer_decode.v ***
// Status-register transfer decode and single-cycle execute
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`include "psr_xfer_consts.vh"

// What this block does
// - Flag-only write decoded from bits 27:26, 24:23 and fixed 1010011111 pattern.
// - Bit 22 picks current status word or the single, unbanked saved status word.
// - Bit 25 low takes source from register in bits 3:0; 11:4 zero.
// - Immediate form builds 32-bit source from 8-bit value and 4-bit rotate.
// - Only twelve status bits exist; reserved bits are not stored.
// - Register flag write copies top four bits into N,Z,C,V only.
// - Immediate flag write takes top four bits of expanded immediate.
// - Every transfer completes in one cycle, no extra internal cycles.
// - Mode field sits in low five bits of status word.
// - In user mode a full write to the current status word changes only the flags in 31:28.
// - Instruction acts only when its condition passes on current flags.
module psr_transfer_decode
(
  input  wire        I_SYS_CLK,
  input  wire        I_RSTN,
  input  wire        i_instr_valid,
  input  wire [31:0] i_instr,
  input  wire [31:0] i_src_data,
  input  wire [31:0] i_wr_addr,
  input  wire [31:0] i_wr_data,
  input  wire        i_wr_stb,
  input  wire        i_rd_stb,
  output wire [3:0]  o_src_reg,
  output reg         o_gp_we,
  output reg  [3:0]  o_gp_waddr,
  output reg  [31:0] o_gp_wdata,
  output reg         o_done,
  output reg         o_illegal,
  output reg  [31:0] o_status,
  output reg  [31:0] o_saved_status,
  output reg  [31:0] o_rd_data
);

  // ----------------------------------------------------------------
  // Register file offsets for software access
  // ----------------------------------------------------------------
  localparam [31:0] ADDR_STATUS = `OFS_STATUS;
  localparam [31:0] ADDR_SAVED  = `OFS_SAVED;
  localparam [31:0] ADDR_INFO   = `OFS_INFO;

  // ----------------------------------------------------------------
  // Instruction field decode
  // ----------------------------------------------------------------
  wire [3:0] cond    = i_instr[`COND_HI:`COND_LO];
  wire       is_imm  = i_instr[`IMM_BIT];
  wire       sel_sav = i_instr[`SEL_BIT];
  wire [3:0] rot     = i_instr[`ROT_HI:`ROT_LO];
  wire [7:0] imm8    = i_instr[`IMM8_HI:`IMM8_LO];

  // Flag-only write: register or immediate source; the register form also
  // needs an all-zero pad, otherwise the word is not this instruction
  wire dec_flg = (i_instr[`CLS_HI:`CLS_LO] == `CLS_VAL) &&
                 (i_instr[`OPC_HI:`OPC_LO] == `OPC_VAL) &&
                 (i_instr[`FLGPAT_HI:`FLGPAT_LO] == `FLGPAT_VAL) &&
                 (is_imm || (i_instr[`PAD_HI:`PAD_LO] == `PAD_VAL));
  // Full write from register: bit 16 of the fixed field tells it apart
  // from the flag form, so the two decodes never match one word
  wire dec_full = (i_instr[`TOPCLS_HI:`TOPCLS_LO] == `TOPCLS_VAL) && !is_imm &&
                  (i_instr[`FLGPAT_HI:`FLGPAT_LO] == `FULLPAT_VAL) &&
                  (i_instr[`PAD_HI:`PAD_LO] == `PAD_VAL);
  // Read of a status word into a general register
  wire dec_read = (i_instr[`TOPCLS_HI:`TOPCLS_LO] == `TOPCLS_VAL) && !is_imm &&
                  (i_instr[`RDPAT_HI:`RDPAT_LO] == `RDPAT_VAL) &&
                  (i_instr[`RDZERO_HI:`RDZERO_LO] == 12'h000);

  assign o_src_reg = i_instr[`RM_HI:`RM_LO];

  // ----------------------------------------------------------------
  // Immediate expansion
  // ----------------------------------------------------------------
  // Rotate right by twice the field; doubled value fits five bits
  // Two copies side by side turn a plain shift into a rotate
  wire [4:0]  rot2   = {rot, 1'b0};
  wire [63:0] dbl    = {24'h000000, imm8, 24'h000000, imm8};
  wire [63:0] shr    = dbl >> rot2;
  wire [31:0] imm32  = shr[31:0];
  wire [31:0] src    = is_imm ? imm32 : i_src_data;

  // ----------------------------------------------------------------
  // Status storage: only defined bits kept
  // ----------------------------------------------------------------
  // One saved word, not banked per mode; user mode is not fenced off from it
  reg  [31:0] status_q;
  reg  [31:0] saved_q;
  reg  [31:0] status_d;
  reg  [31:0] saved_d;
  wire [3:0]  flg = status_q[`FLAGS_HI:`FLAGS_LO];
  wire        user_mode = (status_q[`MODE_HI:`MODE_LO] == `MODE_USER);

  // Condition evaluation on current flags
  // Code 0xf is taken as never, so such words retire with no effect
  reg cond_ok;
  always @*
  begin
    case (cond)
      4'h0:    cond_ok = flg[2];
      4'h1:    cond_ok = !flg[2];
      4'h2:    cond_ok = flg[1];
      4'h3:    cond_ok = !flg[1];
      4'h4:    cond_ok = flg[3];
      4'h5:    cond_ok = !flg[3];
      4'h6:    cond_ok = flg[0];
      4'h7:    cond_ok = !flg[0];
      4'h8:    cond_ok = flg[1] && !flg[2];
      4'h9:    cond_ok = !flg[1] || flg[2];
      4'ha:    cond_ok = (flg[3] == flg[0]);
      4'hb:    cond_ok = (flg[3] != flg[0]);
      4'hc:    cond_ok = !flg[2] && (flg[3] == flg[0]);
      4'hd:    cond_ok = flg[2] || (flg[3] != flg[0]);
      4'he:    cond_ok = 1'b1;
      default: cond_ok = 1'b0;
    endcase
  end

  // Reserved bits are never stored; they read back as zero
  wire        go       = i_instr_valid && cond_ok;
  wire [31:0] sel_word = sel_sav ? saved_q : status_q;
  wire        pc_named = (dec_read && (i_instr[`RD_HI:`RD_LO] == `PC_REG)) ||
                         ((dec_full || (dec_flg && !is_imm)) && (o_src_reg == `PC_REG));
  // An instruction that really changes a status word outranks software;
  // a refused one (program counter named) lets the software write land
  wire        instr_wr = go && !pc_named && (dec_flg || dec_full);

  // Next-state of both status words
  always @*
  begin
    status_d = status_q;
    saved_d  = saved_q;
    if (go && !pc_named)
    begin
      if (dec_flg)
      begin
        // Flags only; control byte untouched
        if (sel_sav)
          saved_d[`FLAGS_HI:`FLAGS_LO] = src[`FLAGS_HI:`FLAGS_LO];
        else
          status_d[`FLAGS_HI:`FLAGS_LO] = src[`FLAGS_HI:`FLAGS_LO];
      end
      else if (dec_full)
      begin
        if (sel_sav)
          saved_d = src & `DEFINED_MASK;
        else if (user_mode)
          status_d[`FLAGS_HI:`FLAGS_LO] = src[`FLAGS_HI:`FLAGS_LO];
        else
          status_d = src & `DEFINED_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // State and outputs; everything retires one cycle after it arrives
  // ----------------------------------------------------------------
  always @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      status_q       <= `STATUS_RESET;
      saved_q        <= 32'h00000000;
      o_gp_we        <= 1'b0;
      o_gp_waddr     <= 4'h0;
      o_gp_wdata     <= 32'h00000000;
      o_done         <= 1'b0;
      o_illegal      <= 1'b0;
      o_status       <= `STATUS_RESET;
      o_saved_status <= 32'h00000000;
      o_rd_data      <= 32'h00000000;
    end
    else
    begin
      status_q       <= status_d;
      saved_q        <= saved_d;
      o_status       <= status_d;
      o_saved_status <= saved_d;
      o_done         <= i_instr_valid && (dec_flg || dec_full || dec_read);
      o_illegal      <= i_instr_valid && (!(dec_flg || dec_full || dec_read) || pc_named);
      o_gp_we        <= go && dec_read && !pc_named;
      o_gp_waddr     <= i_instr[`RD_HI:`RD_LO];
      o_gp_wdata     <= sel_word;
      // Software window, answer one cycle after the read strobe
      // Reads show the word as it stood before this edge's update
      if (i_rd_stb)
      begin
        case (i_wr_addr)
          ADDR_STATUS: o_rd_data <= status_q;
          ADDR_SAVED:  o_rd_data <= saved_q;
          ADDR_INFO:   o_rd_data <= {31'h00000000, user_mode};
          default:     o_rd_data <= 32'h00000000;
        endcase
      end
      else
        o_rd_data <= 32'h00000000;
      // Debug write path; a same-cycle instruction write wins, since
      // software is only a side door for test and bring-up
      if (i_wr_stb && !instr_wr)
      begin
        if (i_wr_addr == ADDR_STATUS)
        begin
          status_q <= i_wr_data & `DEFINED_MASK;
          o_status <= i_wr_data & `DEFINED_MASK;
        end
        else if (i_wr_addr == ADDR_SAVED)
        begin
          saved_q        <= i_wr_data & `DEFINED_MASK;
          o_saved_status <= i_wr_data & `DEFINED_MASK;
        end
      end
    end
  end

endmodule

// *** tb/psr_transfer_decode_sva.sv ***
// Checker for the status-transfer decoder
`timescale 1ns/1ps
module psr_transfer_decode_sva
(
  input wire        I_SYS_CLK,
  input wire        I_RSTN,
  input wire        i_instr_valid,
  input wire [31:0] i_instr,
  input wire [31:0] i_src_data,
  input wire        i_wr_stb,
  input wire [3:0]  o_src_reg,
  input wire        o_gp_we,
  input wire [3:0]  o_gp_waddr,
  input wire [31:0] o_gp_wdata,
  input wire        o_done,
  input wire        o_illegal,
  input wire [31:0] o_status,
  input wire [31:0] o_saved_status
);
  // ------
  // Decode helpers; software writes mask stability claims
  // ------
  wire [3:0]  cnd = i_instr[31:28];
  wire        go  = i_instr_valid && cnd == 4'he && !i_wr_stb;
  wire        flg = i_instr[27:26] == 2'h0 && i_instr[24:23] == 2'h2 && i_instr[21:12] == 10'h29f;
  wire        rdf = i_instr[27:23] == 5'h02 && i_instr[21:16] == 6'h0f && i_instr[11:0] == 12'h000;
  wire [63:0] rot = {2{24'h000000, i_instr[7:0]}} >> {i_instr[11:8], 1'b0};
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  one_cycle_a: assert property (i_instr_valid |=> o_done || o_illegal)
    else $error("transfer did not retire next cycle");
  no_extra_a: assert property (!i_instr_valid |=> !o_done && !o_gp_we)
    else $error("retire without instruction");
  imm_flags_a: assert property (go && flg && i_instr[25] && !i_instr[22]
    |=> o_status[31:28] == $past(rot[31:28]) && o_status[27:0] == $past(o_status[27:0]))
    else $error("immediate flag write wrong");
  reg_flags_a: assert property (go && flg && !i_instr[25] && !i_instr[22] && i_instr[3:0] != 4'hf
    && i_instr[11:4] == 8'h00
    |=> o_status[31:28] == $past(i_src_data[31:28]) && o_status[7:0] == $past(o_status[7:0]))
    else $error("register flag write wrong");
  saved_sel_a: assert property (go && flg && i_instr[25] && i_instr[22]
    |=> o_saved_status[31:28] == $past(rot[31:28]) && $stable(o_status))
    else $error("saved word not selected");
  read_all_a: assert property (go && rdf && i_instr[15:12] != 4'hf |=> o_gp_we &&
    o_gp_waddr == $past(i_instr[15:12]) && o_gp_wdata == ($past(i_instr[22]) ? $past(o_saved_status) : $past(o_status)))
    else $error("status read wrong");
  cond_never_a: assert property (i_instr_valid && cnd == 4'hf && !i_wr_stb
    |=> !o_gp_we && $stable(o_status) && $stable(o_saved_status))
    else $error("failed condition had effect");
  pc_refused_a: assert property (go && flg && !i_instr[25] && i_instr[3:0] == 4'hf
    |=> o_illegal && $stable(o_status)) else $error("pc operand accepted");
  reserved_a: assert property (o_status[27:8] == 20'h0 && o_saved_status[27:8] == 20'h0)
    else $error("reserved bits stored");
  src_sel_a: assert property (o_src_reg == i_instr[3:0])
    else $error("source register select wrong");
  user_full_a: assert property (go && i_instr[27:23] == 5'h02 && i_instr[22:12] == 11'h28f
    && i_instr[11:4] == 8'h00 && i_instr[3:0] != 4'hf && o_status[4:0] == 5'h10
    |=> o_status[31:28] == $past(i_src_data[31:28]) && o_status[27:0] == $past(o_status[27:0]))
    else $error("user full write touched control bits");
  priv_full_a: assert property (go && i_instr[27:23] == 5'h02 && i_instr[22:12] == 11'h28f
    && i_instr[11:4] == 8'h00 && i_instr[3:0] != 4'hf && o_status[4:0] != 5'h10
    |=> o_status == ($past(i_src_data) & 32'hf00000ff))
    else $error("privileged full write wrong");
  // Main scenarios reached
  cover property (go && flg && i_instr[25]);
  cover property (go && rdf);
  cover property (i_instr_valid && cnd == 4'hf);
  cover property (go && i_instr[27:23] == 5'h02 && i_instr[21:12] == 10'h28f);
endmodule
bind psr_transfer_decode psr_transfer_decode_sva chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN),
  .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_src_data(i_src_data), .i_wr_stb(i_wr_stb),
  .o_src_reg(o_src_reg), .o_gp_we(o_gp_we), .o_gp_waddr(o_gp_waddr), .o_gp_wdata(o_gp_wdata),
  .o_done(o_done), .o_illegal(o_illegal), .o_status(o_status), .o_saved_status(o_saved_status));

// *** tb/psr_transfer_decode_test.sv ***
// Self-checking testbench for the status-transfer decoder
`timescale 1ns/1ps
module psr_transfer_decode_test;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         vld = 1'b0;
  reg  [31:0] ins = 32'h0;
  reg  [31:0] src = 32'h0;
  reg  [31:0] adr = 32'h0;
  reg  [31:0] wdt = 32'h0;
  reg         wst = 1'b0;
  reg         rds = 1'b0;
  reg  [31:0] rv;
  wire [3:0]  sreg;
  wire        we;
  wire [3:0]  wa;
  wire [31:0] wd;
  wire        done;
  wire        ill;
  wire [31:0] st;
  wire [31:0] sv;
  wire [31:0] rd;
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     k;
  localparam [47:0] IMMS = {12'h20f, 12'h103, 12'h0c0, 12'h20a};
  localparam [15:0] FLGS = {4'hf, 4'hc, 4'h0, 4'ha};
  psr_transfer_decode dut_u (.I_SYS_CLK(clk), .I_RSTN(rstn), .i_instr_valid(vld), .i_instr(ins),
    .i_src_data(src), .i_wr_addr(adr), .i_wr_data(wdt), .i_wr_stb(wst), .i_rd_stb(rds), .o_src_reg(sreg),
    .o_gp_we(we), .o_gp_waddr(wa), .o_gp_wdata(wd), .o_done(done), .o_illegal(ill), .o_status(st),
    .o_saved_status(sv), .o_rd_data(rd));
  // ------
  // Access tasks; outputs read 1 ns after the answering edge
  // ------
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task exec(input [31:0] i, input [31:0] s);
    begin
      @(posedge clk);
      vld <= 1'b1;
      ins <= i;
      src <= s;
      @(posedge clk);
      vld <= 1'b0;
      #1;
    end
  endtask
  task sw(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge clk);
      wst <= w;
      rds <= !w;
      adr <= a;
      wdt <= d;
      @(posedge clk);
      wst <= 1'b0;
      rds <= 1'b0;
      #1;
      rv = rd;
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Clock and watchdog; whole run is well under 200 cycles
  initial
    forever #12.5 clk = ~clk;
  initial
  begin
    #100000;
    miscompares = miscompares + 1;
    end_sim;
  end
  // ------
  // Scenarios
  // ------
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    check("reset status", st, 32'h000000d3);
    // Top nibble of the expanded immediate, never of the 8-bit field
    for (k = 0; k < 4; k = k + 1)
    begin
      exec(32'he329f000 | IMMS[k*12 +: 12], 32'h0);
      check("imm flags", st, {FLGS[k*4 +: 4], 28'h00000d3});
      check("imm done", done, 32'h1);
    end
    exec(32'he129f002, 32'h5fffff00);
    check("reg flags", st, 32'h500000d3);
    check("src reg", sreg, 32'h2);
    exec(32'he169f004, 32'h9000abcd);
    check("saved reg flags", sv, 32'h90000000);
    exec(32'he369f20c, 32'h0);
    check("saved imm flags", sv, 32'hc0000000);
    check("cur untouched", st, 32'h500000d3);
    exec(32'he10f3000, 32'h0);
    check("read we", we, 32'h1);
    check("read addr", wa, 32'h3);
    check("read cur", wd, 32'h500000d3);
    exec(32'he14f7000, 32'h0);
    check("read saved", wd, 32'hc0000000);
    exec(32'hf329f000, 32'h0);
    check("never", st, 32'h500000d3);
    check("never done", done, 32'h1);
    exec(32'h1329f000, 32'h0);
    check("ne with z set", st, 32'h500000d3);
    exec(32'h0329f20f, 32'h0);
    check("eq with z set", st, 32'hf00000d3);
    exec(32'he129f00f, 32'h0);
    check("pc illegal", ill, 32'h1);
    check("pc no effect", st, 32'hf00000d3);
    sw(1'b0, 32'h0, 32'h0);
    check("sw read status", rv, 32'hf00000d3);
    sw(1'b1, 32'h4, 32'hffffffff);
    sw(1'b0, 32'h4, 32'h0);
    check("reserved dropped", rv, 32'hf00000ff);
    // Full writes: saved word first, then a mode change done as read, mask, write-back
    exec(32'he168f000, 32'h123456ff);
    check("saved full", sv, 32'h100000ff);
    exec(32'he10f0000, 32'h0);
    check("rmw copy", wd, 32'hf00000d3);
    exec(32'he128f000, (wd & 32'hffffffe0) | 32'h00000010);
    check("mode change", st, 32'hf00000d0);
    sw(1'b0, 32'h8, 32'h0);
    check("user mode seen", rv, 32'h1);
    exec(32'he128f000, 32'h000000d3);
    check("user full write", st, 32'h000000d0);
    sw(1'b0, 32'h20, 32'h0);
    check("unmapped read", rv, 32'h0);
    end_sim;
  end
endmodule
